// file: rtl/cmh_ctrl.sv
// status flags, interrupt mask, dma and configuration registers of the card host
//
// The implementer's own choice: strobed register access.
`timescale 1ns/1ps
`include "cmh_consts.svh"

module cmh_ctrl (
	input wire logic ref_clk_i,
	input wire logic reset_i,
	input wire logic clk_en_i,
	input wire logic [31:0] addr_i,
	input wire logic [31:0] wdata_i,
	input wire logic wr_i,
	input wire logic rd_i,
	output logic [31:0] rdata_o,
	input wire logic [26:0] status_low_i,
	input wire logic cmd_ready_i,
	input wire logic data_idle_i,
	input wire logic boot_ack_i,
	input wire logic boot_ack_bad_i,
	input wire logic rx_byte_lost_i,
	input wire logic tx_byte_empty_i,
	input wire logic data_cmd_i,
	input wire logic card_clk_i,
	input wire logic [15:0] block_length_i,
	input wire logic [16:0] fifo_level_i,
	input wire logic cmd_pending_i,
	input wire logic block_end_i,
	input wire logic xfer_end_i,
	input wire logic [15:0] block_count_i,
	output logic irq_o,
	output logic dma_req_o,
	output logic dma_handshake_enable_o,
	output logic [1:0] dma_offset_o,
	output logic [4:0] dma_chunk_size_o,
	output logic [15:0] dma_bytes_o,
	output logic dma_two_desc_o,
	output logic write_start_o,
	output logic drive_strobe_o,
	output logic high_speed_timing_o,
	output logic cmd_send_o
);
	import cmh_pkg::*;

	cmh_state_t st_r;
	cmh_state_t st_nxt;

	logic [31:0] status_now;
	logic sr_read;
	logic wr_set;
	logic wr_clr;
	logic wr_dma;
	logic wr_cfg;
	logic clk_rise;
	logic clk_fall;
	logic [16:0] blk_w;
	logic [16:0] chunk_bytes;
	logic [16:0] pad_sum;
	logic [16:0] start_level;

	always_comb
	begin
		status_now = {st_r.transmit_underrun_flag, st_r.receive_overrun_flag, st_r.ack_err, st_r.ack_rcv,
			st_r.xfr_done, status_low_i};
		sr_read = rd_i && (addr_i == `CMH_ADDR_STATUS);
		wr_dma = wr_i && (addr_i == `CMH_ADDR_DMA);
		wr_cfg = wr_i && (addr_i == `CMH_ADDR_CFG);
		// full 32-bit compare: no aliases answer inside the block
		wr_set = wr_i && (addr_i == `CMH_ADDR_IEN_SET);
		wr_clr = wr_i && (addr_i == `CMH_ADDR_IEN_CLR);
		blk_w = {1'b0, block_length_i};
		chunk_bytes = {12'h000, st_r.chunk} * `CMH_WORD_BYTES;
		pad_sum = blk_w + 17'h00003;
		// mask, dma and cfg fields and the sticky flags hold unless a write, a status read or an event moves them
		st_nxt = st_r;

		// register writes
		// reserved mask bits are dropped so the view never shows them
		if (wr_set)
		begin
			st_nxt.mask = st_r.mask | (wdata_i & `CMH_IRQ_VALID);
		end
		if (wr_clr)
		begin
			st_nxt.mask = st_r.mask & ~wdata_i;
		end
		if (wr_dma)
		begin
			st_nxt.dma_off = wdata_i[`CMH_DMA_OFS_LSB +: 2];
			st_nxt.dma_chk = wdata_i[`CMH_DMA_CHK_LSB +: 2];
			st_nxt.dma_en = wdata_i[`CMH_DMA_EN_BIT];
			st_nxt.read_padding_option = wdata_i[`CMH_DMA_READ_PADDING_OPTION_BIT];
		end
		if (wr_cfg)
		begin
			st_nxt.fifo_mode = wdata_i[`CMH_CFG_FIFO_BIT];
			st_nxt.ferr = wdata_i[`CMH_CFG_FERR_BIT];
			st_nxt.hs = wdata_i[`CMH_CFG_HS_BIT];
			st_nxt.last_block_sync = wdata_i[`CMH_CFG_LAST_BLOCK_SYNC_BIT];
		end

		// read data stands only in the cycle after the strobe
		st_nxt.rdata = 32'h00000000;
		if (rd_i)
		begin
			unique case (addr_i)
				`CMH_ADDR_STATUS:
				begin
					st_nxt.rdata = status_now;
				end
				`CMH_ADDR_IMASK:
				begin
					st_nxt.rdata = st_r.mask;
				end
				`CMH_ADDR_DMA:
				begin
					st_nxt.rdata[`CMH_DMA_OFS_LSB +: 2] = st_r.dma_off;
					st_nxt.rdata[`CMH_DMA_CHK_LSB +: 2] = st_r.dma_chk;
					st_nxt.rdata[`CMH_DMA_EN_BIT] = st_r.dma_en;
					st_nxt.rdata[`CMH_DMA_READ_PADDING_OPTION_BIT] = st_r.read_padding_option;
				end
				`CMH_ADDR_CFG:
				begin
					st_nxt.rdata[`CMH_CFG_FIFO_BIT] = st_r.fifo_mode;
					st_nxt.rdata[`CMH_CFG_FERR_BIT] = st_r.ferr;
					st_nxt.rdata[`CMH_CFG_HS_BIT] = st_r.hs;
					st_nxt.rdata[`CMH_CFG_LAST_BLOCK_SYNC_BIT] = st_r.last_block_sync;
				end
				default:
				begin
					st_nxt.rdata = 32'h00000000;
				end
			endcase
		end

		// flags: clears first, so a set in the same cycle wins
		if (cmd_ready_i && data_idle_i)
		begin
			st_nxt.xfr_done = 1'b1;
		end
		else
		begin
			st_nxt.xfr_done = 1'b0;
		end

		// the error flag goes with the received flag, so one read resets both
		if (sr_read)
		begin
			st_nxt.ack_rcv = 1'b0;
			st_nxt.ack_err = 1'b0;
		end
		if (boot_ack_i)
		begin
			st_nxt.ack_rcv = 1'b1;
		end
		if (boot_ack_bad_i)
		begin
			st_nxt.ack_err = 1'b1;
		end
		if (data_cmd_i)
		begin
			st_nxt.receive_overrun_flag = 1'b0;
			st_nxt.transmit_underrun_flag = 1'b0;
		end
		if (sr_read && st_r.ferr)
		begin
			st_nxt.receive_overrun_flag = 1'b0;
			st_nxt.transmit_underrun_flag = 1'b0;
		end
		if (wr_cfg && wdata_i[`CMH_CFG_FERR_BIT])
		begin
			st_nxt.transmit_underrun_flag = 1'b0;
		end
		if (rx_byte_lost_i)
		begin
			st_nxt.receive_overrun_flag = 1'b1;
		end
		if (tx_byte_empty_i)
		begin
			st_nxt.transmit_underrun_flag = 1'b1;
		end

		// irq follows registered flags, status_low_i and mask, one cycle behind them
		if (|(status_now & st_r.mask))
		begin
			st_nxt.irq = 1'b1;
		end
		else
		begin
			st_nxt.irq = 1'b0;
		end

		// card clock: only s2 reads s1; filtered level moves when s2 and s3 agree
		st_nxt.sync = {st_r.sync[1:0], card_clk_i};
		if (st_r.sync[1] == st_r.sync[2])
		begin
			st_nxt.clk_f = st_r.sync[2];
		end
		clk_rise = st_nxt.clk_f && !st_r.clk_f;
		clk_fall = !st_nxt.clk_f && st_r.clk_f;
		// default timing launches on the falling edge, so data settles for the rise
		if (st_r.hs)
		begin
			st_nxt.strobe = clk_rise;
		end
		else
		begin
			st_nxt.strobe = clk_fall;
		end

		// dma handshake
		unique case (st_r.dma_chk)
			2'b00:
			begin
				st_nxt.chunk = 5'h01;
			end
			2'b01:
			begin
				st_nxt.chunk = 5'h04;
			end
			2'b10:
			begin
				st_nxt.chunk = 5'h08;
			end
			2'b11:
			begin
				st_nxt.chunk = 5'h10;
			end
		endcase
		// relies on software keeping this low while the cpu moves data
		if (st_r.dma_en && (fifo_level_i >= chunk_bytes))
		begin
			st_nxt.req = 1'b1;
		end
		else
		begin
			st_nxt.req = 1'b0;
		end
		if (st_r.read_padding_option)
		begin
			st_nxt.bytes = pad_sum[15:0] & 16'hFFFC;
			st_nxt.two_desc = 1'b0;
		end
		else
		begin
			st_nxt.bytes = block_length_i;
			// a length off the word grid leaves a tail needing its own descriptor
			if (block_length_i[1:0] != 2'b00)
			begin
				st_nxt.two_desc = 1'b1;
			end
			else
			begin
				st_nxt.two_desc = 1'b0;
			end
		end

		// write start threshold
		if (blk_w >= ((`CMH_FIFO_BYTES >> 2) * 17'h00003))
		begin
			start_level = `CMH_FIFO_BYTES >> 1;
		end
		else if (blk_w >= (`CMH_FIFO_BYTES >> 1))
		begin
			start_level = `CMH_FIFO_BYTES >> 2;
		end
		else
		begin
			start_level = blk_w;
		end
		if (st_r.fifo_mode)
		begin
			start_level = `CMH_WORD_BYTES;
		end
		if (fifo_level_i >= start_level)
		begin
			st_nxt.wstart = 1'b1;
		end
		else
		begin
			st_nxt.wstart = 1'b0;
		end

		// pending command release
		st_nxt.cmd_send = 1'b0;
		if (cmd_pending_i)
		begin
			// infinite transfers have no end of transfer, so they sync per block
			if (st_r.last_block_sync && (block_count_i != 16'h0000))
			begin
				st_nxt.cmd_send = xfer_end_i;
			end
			else
			begin
				st_nxt.cmd_send = block_end_i;
			end
		end
	end

	always_ff @(posedge ref_clk_i)
	begin
		if (reset_i)
		begin
			st_r <= '0;
			st_r.mask <= `CMH_MASK_RESET;
		end
		else if (clk_en_i)
		begin
			st_r <= st_nxt;
		end
	end

	assign rdata_o = st_r.rdata;
	assign irq_o = st_r.irq;
	assign dma_req_o = st_r.req;
	assign dma_handshake_enable_o = st_r.dma_en;
	assign dma_offset_o = st_r.dma_off;
	assign dma_chunk_size_o = st_r.chunk;
	assign dma_bytes_o = st_r.bytes;
	assign dma_two_desc_o = st_r.two_desc;
	assign write_start_o = st_r.wstart;
	assign drive_strobe_o = st_r.strobe;
	assign high_speed_timing_o = st_r.hs;
	assign cmd_send_o = st_r.cmd_send;

endmodule // cmh_ctrl

// file: rtl/cmh_consts.svh
// register offsets, field positions and reset values of the card host control block
`ifndef CMH_CONSTS_SVH
`define CMH_CONSTS_SVH

`define CMH_ADDR_STATUS 32'hFFF80040
`define CMH_ADDR_IEN_SET 32'hFFF80044
`define CMH_ADDR_IEN_CLR 32'hFFF80048
`define CMH_ADDR_IMASK 32'hFFF8004C
`define CMH_ADDR_DMA 32'hFFF80050
`define CMH_ADDR_CFG 32'hFFF80054

`define CMH_SR_UNDERRUN 31
`define CMH_SR_OVERRUN 30
`define CMH_SR_ACK_ERR 29
`define CMH_SR_ACK_RCV 28
`define CMH_SR_XFR_DONE 27
`define CMH_SR_LOW_W 27

`define CMH_IRQ_VALID 32'hFFFF313F
`define CMH_MASK_RESET 32'h00000000

`define CMH_DMA_OFS_LSB 0
`define CMH_DMA_CHK_LSB 4
`define CMH_DMA_EN_BIT 8
`define CMH_DMA_READ_PADDING_OPTION_BIT 12
`define CMH_DMA_RESET 32'h00000000

`define CMH_CFG_FIFO_BIT 0
`define CMH_CFG_FERR_BIT 4
`define CMH_CFG_HS_BIT 8
`define CMH_CFG_LAST_BLOCK_SYNC_BIT 12
`define CMH_CFG_RESET 32'h00000000

`define CMH_FIFO_BYTES 17'h00400
`define CMH_WORD_BYTES 17'h00004

`endif

// file: rtl/cmh_pkg.sv
// types of the card host control block
package cmh_pkg;

	typedef struct packed {
		logic [31:0] mask;
		logic [1:0] dma_off;
		logic [1:0] dma_chk;
		logic dma_en;
		logic read_padding_option;
		logic fifo_mode;
		logic ferr;
		logic hs;
		logic last_block_sync;
		logic ack_rcv;
		logic ack_err;
		logic receive_overrun_flag;
		logic transmit_underrun_flag;
		logic xfr_done;
		logic [31:0] rdata;
		logic irq;
		logic [2:0] sync;
		logic clk_f;
		logic strobe;
		logic req;
		logic [4:0] chunk;
		logic [15:0] bytes;
		logic two_desc;
		logic wstart;
		logic cmd_send;
	} cmh_state_t;

endpackage

// file: tb/cmh_ctrl_props.sv
// assertion checker for the card host control block
`timescale 1ns/1ps
module cmh_ctrl_props (
	input wire logic ref_clk_i,
	input wire logic reset_i,
	input wire logic clk_en_i,
	input wire logic [31:0] addr_i,
	input wire logic [31:0] wdata_i,
	input wire logic wr_i,
	input wire logic rd_i,
	input wire logic [31:0] rdata_o,
	input wire logic cmd_pending_i,
	input wire logic block_end_i,
	input wire logic xfer_end_i,
	input wire logic cmd_send_o,
	input wire logic drive_strobe_o,
	input wire logic high_speed_timing_o,
	input wire logic dma_handshake_enable_o,
	input wire logic dma_req_o,
	input wire logic [4:0] dma_chunk_size_o
);
	default clocking @(posedge ref_clk_i); endclocking
	default disable iff (reset_i);
	a_read_idle_zero: assert property ($past(!rd_i && clk_en_i) |-> rdata_o == 0)
		else $error("read data not idle");
	a_enset_reads_zero: assert property ($past(rd_i && clk_en_i && addr_i == 32'hFFF80044)
		|-> rdata_o == 0) else $error("enable set register readable");
	a_cmd_send_cause: assert property (cmd_send_o && $past(clk_en_i)
		|-> $past(cmd_pending_i && (block_end_i || xfer_end_i))) else $error("command sent uncaused");
	a_strobe_single: assert property (drive_strobe_o && clk_en_i |=> !drive_strobe_o)
		else $error("strobe too long");
	a_hs_follows_cfg: assert property ($past(wr_i && clk_en_i && addr_i == 32'hFFF80054)
		|-> high_speed_timing_o == $past(wdata_i[8])) else $error("high speed bit wrong");
	a_dma_en_follows: assert property ($past(wr_i && clk_en_i && addr_i == 32'hFFF80050)
		|-> dma_handshake_enable_o == $past(wdata_i[8])) else $error("dma enable bit wrong");
	a_req_needs_en: assert property (dma_req_o
		|-> dma_handshake_enable_o || $past(dma_handshake_enable_o)) else $error("request while off");
	a_chunk_legal: assert property (dma_chunk_size_o inside {5'h00, 5'h01, 5'h04, 5'h08, 5'h10})
		else $error("chunk count illegal");
endmodule // cmh_ctrl_props
bind cmh_ctrl cmh_ctrl_props props_u (.*);

// file: tb/cmh_card_model.sv
// card side model: card clock that runs only inside frames
`timescale 1ns/1ps
module cmh_card_model (
	input wire logic run_i,
	output logic card_clk_o
);
	initial card_clk_o = 1'h0;
	// odd offset keeps card edges clear of reference edges; stops low
	always @(posedge run_i)
	begin
		#37;
		while (run_i)
		begin
			#400 card_clk_o = ~card_clk_o;
		end
	end
endmodule // cmh_card_model

// file: tb/cmh_ctrl_tb_top.sv
// self-checking bench for the card host control block
`timescale 1ns/1ps
module cmh_ctrl_tb_top;
	localparam logic [31:0] a_sr = 32'hFFF80040, a_set = 32'hFFF80044, a_clr = 32'hFFF80048;
	localparam logic [31:0] a_msk = 32'hFFF8004C, a_dma = 32'hFFF80050, a_cfg = 32'hFFF80054;
	logic ref_clk_i, reset_i, clk_en_i, wr_i, rd_i, cmd_ready_i, data_idle_i, run;
	logic boot_ack_i, boot_ack_bad_i, rx_byte_lost_i, tx_byte_empty_i, data_cmd_i;
	logic card_clk_i, cmd_pending_i, block_end_i, xfer_end_i, irq_o, dma_req_o;
	logic dma_handshake_enable_o, dma_two_desc_o, write_start_o, drive_strobe_o;
	logic high_speed_timing_o, cmd_send_o;
	logic [31:0] addr_i, wdata_i, rdata_o;
	logic [26:0] status_low_i;
	logic [15:0] block_length_i, block_count_i, dma_bytes_o;
	logic [16:0] fifo_level_i;
	logic [6:0] evm;
	logic [4:0] dma_chunk_size_o;
	logic [1:0] dma_offset_o;
	int failures, n_tests, n;
	assign {xfer_end_i, block_end_i, data_cmd_i, tx_byte_empty_i, rx_byte_lost_i,
		boot_ack_bad_i, boot_ack_i} = evm;
	cmh_ctrl dut_u (.*);
	cmh_card_model card_u (.run_i(run), .card_clk_o(card_clk_i));
	task automatic chk(input logic [31:0] seen, exp);
		n_tests++;
		if (seen !== exp)
		begin
			failures++;
			$display("ERROR %0t seen %h expected %h", $time, seen, exp);
		end
	endtask
	task automatic cyc(input int k);
		repeat (k) @(posedge ref_clk_i);
		#1;
	endtask
	task automatic wr(input logic [31:0] a, d);
		@(posedge ref_clk_i);
		addr_i <= a;
		wdata_i <= d;
		wr_i <= 1'h1;
		@(posedge ref_clk_i);
		wr_i <= 1'h0;
	endtask
	task automatic rd(input logic [31:0] a, exp);
		@(posedge ref_clk_i);
		addr_i <= a;
		rd_i <= 1'h1;
		@(posedge ref_clk_i);
		rd_i <= 1'h0;
		#1 chk(rdata_o, exp);
	endtask
	task automatic ev(input logic [6:0] m);
		@(posedge ref_clk_i) evm <= m;
		@(posedge ref_clk_i) evm <= 7'h00;
	endtask
	task automatic fl(input logic [16:0] l);
		@(posedge ref_clk_i) fifo_level_i <= l;
		cyc(2);
	endtask
	task automatic t_mask;
		rd(a_cfg, 32'h0);
		rd(a_msk, 32'h0);
		wr(a_set, 32'hFFFFFFFF);
		rd(a_msk, 32'hFFFF313F);
		wr(a_clr, 32'h0800313F);
		rd(a_msk, 32'hF7FF0000);
		// clock enable low: the write must not land
		@(posedge ref_clk_i) clk_en_i <= 1'h0;
		wr(a_set, 32'h08000000);
		@(posedge ref_clk_i) clk_en_i <= 1'h1;
		rd(a_msk, 32'hF7FF0000);
		rd(a_set, 32'h0);
		rd(32'hFFF80058, 32'h0);
	endtask
	task automatic t_flags;
		chk(32'(irq_o), 32'h0);
		ev(7'h0F);
		cyc(2);
		chk(32'(irq_o), 32'h1);
		rd(a_sr, 32'hF8000123);
		rd(a_sr, 32'hC8000123);
		ev(7'h10);
		rd(a_sr, 32'h08000123);
		wr(a_cfg, 32'h00000010);
		ev(7'h0C);
		rd(a_sr, 32'hC8000123);
		rd(a_sr, 32'h08000123);
		@(posedge ref_clk_i) data_idle_i <= 1'h0;
		rd(a_sr, 32'h00000123);
		@(posedge ref_clk_i) data_idle_i <= 1'h1;
	endtask
	task automatic t_dma;
		for (int c = 0; c < 4; c++)
		begin
			wr(a_dma, 32'h00001101 | (c << 4));
			cyc(2);
			chk(32'(dma_chunk_size_o), 32'h1 << (c ? c + 1 : 0));
		end
		rd(a_dma, 32'h00001131);
		chk(32'(dma_offset_o), 32'h1);
		chk(32'({dma_two_desc_o, dma_bytes_o}), 32'h10);
		fl(17'h40);
		chk(32'(dma_req_o), 32'h1);
		fl(17'h3C);
		chk(32'(dma_req_o), 32'h0);
		wr(a_dma, 32'h00000032); // cpu moves data, handshake off
		fl(17'h40);
		chk(32'(dma_req_o), 32'h0);
		chk(32'({dma_two_desc_o, dma_bytes_o}), 32'h1000D);
		chk(32'(dma_offset_o), 32'h2);
	endtask
	// six card clock periods, then the clock stops low
	task automatic t_link(input logic [31:0] exp);
		n = 0;
		@(posedge ref_clk_i) run <= 1'h1;
		for (int i = 0; i < 60; i++)
		begin
			@(posedge ref_clk_i);
			if (i == 47) run <= 1'h0;
			#1 n += drive_strobe_o;
		end
		chk(n, exp);
	endtask
	task automatic t_cfg;
		logic [15:0] bl[3] = '{16'h0300, 16'h0200, 16'h000D};
		logic [16:0] th[3] = '{17'h00200, 17'h00100, 17'h0000D};
		wr(a_cfg, 32'h00000001);
		fl(17'h4);
		chk(32'(write_start_o), 32'h1);
		fl(17'h3);
		chk(32'(write_start_o), 32'h0);
		wr(a_cfg, 32'h00000000);
		for (int i = 0; i < 3; i++)
		begin
			@(posedge ref_clk_i) block_length_i <= bl[i];
			fl(th[i] - 17'h1);
			chk(32'(write_start_o), 32'h0);
			fl(th[i]);
			chk(32'(write_start_o), 32'h1);
		end
		wr(a_cfg, 32'h00000100); // card known high speed capable
		cyc(1);
		chk(32'(high_speed_timing_o), 32'h1);
		t_link(32'h6); // rising edges
		wr(a_cfg, 32'h00001000);
		cmd_pending_i <= 1'h1;
		ev(7'h20);
		#1 chk(32'(cmd_send_o), 32'h0);
		ev(7'h40);
		#1 chk(32'(cmd_send_o), 32'h1);
		wr(a_cfg, 32'h00000000);
		ev(7'h20);
		#1 chk(32'(cmd_send_o), 32'h1);
		chk(32'(high_speed_timing_o), 32'h0);
		t_link(32'h6); // default timing uses falling edges
	endtask
	task automatic test_done;
		$display("failures %0d tests %0d", failures, n_tests);
		if (failures == 0 && n_tests > 0)
			$display("All tests passed");
		else
			$display("Some tests failed");
		$finish;
	endtask
	initial
	begin
		ref_clk_i = 1'h0;
		forever #50 ref_clk_i = ~ref_clk_i;
	end
	initial
	begin
		{reset_i, clk_en_i, cmd_ready_i, data_idle_i} = 4'hF;
		{wr_i, rd_i, run, cmd_pending_i} = 4'h0;
		evm = 7'h00;
		addr_i = 32'h0;
		wdata_i = 32'h0;
		status_low_i = 27'h0000123;
		block_length_i = 16'h000D;
		block_count_i = 16'h0002;
		fifo_level_i = 17'h0;
		failures = 0;
		n_tests = 0;
		repeat (8) @(posedge ref_clk_i);
		reset_i <= 1'h0;
		t_mask;
		t_flags;
		t_dma;
		t_cfg;
		test_done;
	end
endmodule // cmh_ctrl_tb_top
